// ---- core/dac_control_registers.sv ----
// apb register block controlling a 5-bit voltage-output converter.
// assumes a single apb master on ref_clk, synchronous pin inputs.
//
// Summary of operation
// - control bit 7 turns the converter on when 1, off when 0
// - control bit 5 routes the converter level to pin a
// - control bit 4 routes the level to pin b, independent of bit 5
// - control bits 3:2 pick positive reference; 11 is reserved
// - control bit 0 picks external negative reference, else ground
// - control register at index F2E, implemented bits rw, reset 0
// - level register at index F2F holds the 5-bit code in 4:0
// - code chooses one of 32 levels between the two references
// - reset disables converter, frees both pins, clears the code
// - reading a pin that carries the analog level returns 0
`timescale 1ns/1ns
module dac_control_registers
  import dac_ctl_pkg::*;
(
  input  wire logic                 ref_clk,    // system clock 125 MHz
  input  wire logic                 rst_b,      // async reset, low
  input  wire dac_ctl_pkg::apb_req_t apb_req,   // apb request
  output dac_ctl_pkg::apb_rsp_t     apb_rsp,    // apb answer
  input  wire logic                 pin_a_in,   // digital pin a input
  input  wire logic                 pin_b_in,   // digital pin b input
  output dac_ctl_pkg::dac_cfg_t     dac_cfg,    // settings to ladder
  output logic [4:0]                level_tap,  // active ladder tap
  output logic                      pin_a_read, // pin a digital value
  output logic                      pin_b_read, // pin b digital value
  output logic                      pin_a_dis,  // pin a driver off
  output logic                      pin_b_dis   // pin b driver off
);
  import dac_ctl_pkg::*;

  // whole module state
  typedef struct packed {
    logic [7:0]  ctrl_reg;
    logic [4:0]  level_reg;
    logic [31:0] rdata_reg;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic   access;
  logic   hit_ctrl;
  logic   hit_level;

  // match a byte address against a register address
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] r);
    addr_hit = (a == r);
  endfunction

  assign access    = apb_req.psel && apb_req.penable;
  assign hit_ctrl  = addr_hit(apb_req.paddr, CTRL_ADDR);
  assign hit_level = addr_hit(apb_req.paddr, LEVEL_ADDR);

  // next state: write on the access edge, read data captured in setup
  always_comb begin
    state_next = state_reg;
    if (access && apb_req.pwrite && hit_ctrl) begin
      state_next.ctrl_reg = apb_req.pwdata[7:0] & CTRL_MASK;
    end
    if (access && apb_req.pwrite && hit_level) begin
      state_next.level_reg = apb_req.pwdata[4:0];
    end
    if (apb_req.psel && !apb_req.penable) begin
      if (hit_ctrl) begin
        state_next.rdata_reg = {24'h000000, state_reg.ctrl_reg};
      end else if (hit_level) begin
        state_next.rdata_reg = {27'h0000000, state_reg.level_reg};
      end else begin
        state_next.rdata_reg = 32'h00000000;
      end
    end
  end

  // state register; reset clears every control bit and the code
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{ctrl_reg: CTRL_RESET, level_reg: LEVEL_RESET,
                     rdata_reg: 32'h00000000};
    end else begin
      state_reg <= state_next;
    end
  end

  // apb answer: zero wait states, unmapped address gives pslverr;
  // one driver for the whole struct, field-wise drivers are not portable
  assign apb_rsp = '{pready:  1'b1,
                     pslverr: access && !(hit_ctrl || hit_level),
                     prdata:  state_reg.rdata_reg};

  // decoded settings to the analog side
  assign dac_cfg = '{
    enable:  state_reg.ctrl_reg[ENABLE_BIT],
    pin_a:   state_reg.ctrl_reg[PIN_A_BIT],
    pin_b:   state_reg.ctrl_reg[PIN_B_BIT],
    pos_ref: pos_ref_t'(state_reg.ctrl_reg[POS_REF_LO +: 2]),
    neg_ref: state_reg.ctrl_reg[NEG_REF_BIT],
    level:   state_reg.level_reg
  };

  // ladder tap: code/32 of the span above the negative reference;
  // held at the bottom tap while disabled so the ladder draws no step
  assign level_tap = dac_cfg.enable ? state_reg.level_reg
                                    : LEVEL_RESET;

  // pin a gating
  dac_pin_gate pin_a_gate (
    .connect   (dac_cfg.pin_a),
    .pin_in    (pin_a_in),
    .pin_read  (pin_a_read),
    .drive_off (pin_a_dis)
  );

  // pin b gating, independent of pin a
  dac_pin_gate pin_b_gate (
    .connect   (dac_cfg.pin_b),
    .pin_in    (pin_b_in),
    .pin_read  (pin_b_read),
    .drive_off (pin_b_dis)
  );

  // bus side: a write lands on the access edge, so it shows one edge later
  ctrl_write_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    access && apb_req.pwrite && hit_ctrl |=>
      dac_cfg.enable == $past(apb_req.pwdata[7]))
    else $error("enable did not follow control write");

  pin_indep_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    access && apb_req.pwrite && hit_ctrl |=>
      dac_cfg.pin_a == $past(apb_req.pwdata[5]) &&
      dac_cfg.pin_b == $past(apb_req.pwdata[4]))
    else $error("pin connect bits wrong after write");

  ref_select_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    access && apb_req.pwrite && hit_ctrl |=>
      dac_cfg.pos_ref == $past(apb_req.pwdata[3:2]) &&
      dac_cfg.neg_ref == $past(apb_req.pwdata[0]))
    else $error("reference select wrong after write");

  level_write_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    access && apb_req.pwrite && hit_level |=>
      dac_cfg.level == $past(apb_req.pwdata[4:0]))
    else $error("level code did not follow write");

  unused_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    access && !apb_req.pwrite && hit_ctrl |->
      apb_rsp.prdata[6] == 1'b0 && apb_rsp.prdata[1] == 1'b0 &&
      apb_rsp.prdata[31:8] == 24'h000000)
    else $error("unimplemented bit read nonzero");

  read_ctrl_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    apb_req.psel && !apb_req.penable && hit_ctrl ##1
      access && !apb_req.pwrite |->
      apb_rsp.prdata[7:0] == $past(state_reg.ctrl_reg))
    else $error("control read value wrong");

  level_read_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    apb_req.psel && !apb_req.penable && hit_level ##1
      access && !apb_req.pwrite |->
      apb_rsp.prdata == {27'h0000000, $past(state_reg.level_reg)})
    else $error("level read value wrong");

  unmapped_read_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    apb_req.psel && !apb_req.penable && !(hit_ctrl || hit_level) ##1
      access && !apb_req.pwrite |->
      apb_rsp.prdata == 32'h00000000)
    else $error("unmapped read nonzero");

  regs_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !(access && apb_req.pwrite && (hit_ctrl || hit_level)) |=>
      $stable(state_reg.ctrl_reg) && $stable(state_reg.level_reg))
    else $error("register changed without a mapped write");

  zero_wait_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    apb_req.psel |-> apb_rsp.pready)
    else $error("ready low during a transfer");

  // converter and pin side
  tap_gate_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !dac_cfg.enable |-> level_tap == 5'h00)
    else $error("tap moved while disabled");

  tap_follow_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    dac_cfg.enable |-> level_tap == dac_cfg.level)
    else $error("tap differs from level code");

  pin_read_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    dac_cfg.pin_a || dac_cfg.pin_b |->
      !(dac_cfg.pin_a && pin_a_read) && !(dac_cfg.pin_b && pin_b_read))
    else $error("analog pin read nonzero");

  pin_a_free_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !dac_cfg.pin_a |-> pin_a_read == pin_a_in && !pin_a_dis)
    else $error("free pin a not passed through");

  pin_b_free_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !dac_cfg.pin_b |-> pin_b_read == pin_b_in && !pin_b_dis)
    else $error("free pin b not passed through");

  reset_clear_a: assert property (
    @(posedge ref_clk)
    !rst_b ##1 !rst_b |->
      {dac_cfg, level_tap} == 16'h0000 && !pin_a_dis && !pin_b_dis &&
      apb_rsp.prdata == 32'h00000000)
    else $error("state not cleared in reset");

endmodule // dac_control_registers

// ---- core/dac_ctl_pkg.sv ----
// package for the converter control block: register map, field layout,
// reset values, reference selector codes and the bus carrier structs.
// assumes an apb master with 32-bit data and byte addressing.
package dac_ctl_pkg;

  // register byte addresses (offsets are multiples of four: index*4)
  localparam logic [11:0] CTRL_INDEX   = 12'hF2E;
  localparam logic [11:0] LEVEL_INDEX  = 12'hF2F;
  localparam logic [13:0] CTRL_ADDR    = {CTRL_INDEX, 2'h0};
  localparam logic [13:0] LEVEL_ADDR   = {LEVEL_INDEX, 2'h0};
  localparam int          ADDR_W       = 14;

  // control field positions
  localparam int ENABLE_BIT    = 7;
  localparam int PIN_A_BIT     = 5;
  localparam int PIN_B_BIT     = 4;
  localparam int POS_REF_LO    = 2;
  localparam int NEG_REF_BIT   = 0;

  // implemented bit masks and reset values
  localparam logic [7:0] CTRL_MASK   = 8'hBD;
  localparam logic [7:0] LEVEL_MASK  = 8'h1F;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [4:0] LEVEL_RESET = 5'h00;
  localparam int         LEVEL_COUNT = 32;

  // positive reference selector codes
  typedef enum logic [1:0] {
    POS_SUPPLY = 2'h0,
    POS_EXT    = 2'h1,
    POS_FIXED  = 2'h2,
    POS_RSVD   = 2'h3
  } pos_ref_t;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // decoded converter settings
  typedef struct packed {
    logic     enable;
    logic     pin_a;
    logic     pin_b;
    pos_ref_t pos_ref;
    logic     neg_ref;
    logic [4:0] level;
  } dac_cfg_t;

endpackage

// ---- core/dac_pin_gate.sv ----
// pin gating for one converter output pin: when the pin carries the
// analog level the digital path is overridden.
// assumes pin_in is synchronous to ref_clk.
`timescale 1ns/1ns
module dac_pin_gate (
  input  wire logic connect,   // analog level routed to this pin
  input  wire logic pin_in,    // raw digital pin input
  output logic      pin_read,  // value seen by digital readers
  output logic      drive_off  // force digital output buffer off
);
  // analog pin reads as zero and the digital driver is released
  assign pin_read  = connect ? 1'b0 : pin_in;
  assign drive_off = connect;
endmodule // dac_pin_gate

// ---- testbench/test_dac_control_registers.sv ----
// testbench for the converter control registers: apb tasks, scenarios.
// assumes a zero-wait apb slave and the package register addresses.
`timescale 1ns/1ns
module test_dac_control_registers;
  import dac_ctl_pkg::*;
  logic        ref_clk;
  logic        rst_b;
  logic        pin_a_in;
  logic        pin_b_in;
  apb_req_t    apb_req;
  apb_rsp_t    apb_rsp;
  dac_cfg_t    dac_cfg;
  logic [4:0]  level_tap;
  logic        pin_a_read, pin_b_read, pin_a_dis, pin_b_dis;
  logic [31:0] rd;
  logic        e;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;

  dac_control_registers DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pin_a_in(pin_a_in), .pin_b_in(pin_b_in),
    .dac_cfg(dac_cfg), .level_tap(level_tap), .pin_a_read(pin_a_read),
    .pin_b_read(pin_b_read), .pin_a_dis(pin_a_dis), .pin_b_dis(pin_b_dis)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // watchdog: the run needs under a hundred cycles, so 2000 means a hang
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      complete_run();
    end
  end

  task complete_run;
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    e  = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task t_reset;
    @(negedge ref_clk);
    check({dac_cfg, level_tap}, 32'h0);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, LEVEL_ADDR, 32'h0);
    check(rd, 32'h0);
  endtask

  // every selector code, pins switched in the two combinations with one pin connected
  task t_ctrl;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {i[0], 1'b1, i[1], ~i[1], i[1:0], 1'b1, ~i[0]};
      apb(1'b1, CTRL_ADDR, {24'hFFFFFF, v});
      // pin levels differ per pass so a free pin must pass them through
      pin_a_in <= i[0];
      pin_b_in <= ~i[0];
      @(negedge ref_clk);
      check({dac_cfg.enable, dac_cfg.pin_a, dac_cfg.pin_b},
            {v[7], v[5], v[4]});
      check({dac_cfg.pos_ref, dac_cfg.neg_ref},
            {v[3:2], v[0]});
      check({pin_a_read, pin_b_read, pin_a_dis, pin_b_dis},
            {v[5] ? 1'b0 : i[0], v[4] ? 1'b0 : ~i[0],
             v[5], v[4]});
      apb(1'b0, CTRL_ADDR, 32'h0);
      check(rd, v & CTRL_MASK);
    end
  endtask

  task t_level;
    apb(1'b1, LEVEL_ADDR, 32'hFFFFFFFF);
    apb(1'b0, LEVEL_ADDR, 32'h0);
    check(rd, 32'h1F);
    apb(1'b1, CTRL_ADDR, 32'h80);
    @(negedge ref_clk);
    check(level_tap, 5'h1F);
    apb(1'b1, LEVEL_ADDR, 32'h0A);
    @(negedge ref_clk);
    check({dac_cfg.level, level_tap}, 10'h14A);
    apb(1'b1, CTRL_ADDR, 32'h0);
    @(negedge ref_clk);
    check(level_tap, 5'h00);
  endtask

  // the word just past the level register must not alias a register
  task t_unmapped;
    apb(1'b1, CTRL_ADDR, 32'hBD);
    apb(1'b1, LEVEL_ADDR + 14'h4, 32'h0);
    check(e, 1'b1);
    apb(1'b0, LEVEL_ADDR + 14'h4, 32'h0);
    check(e, 1'b1);
    check(rd, 32'h0);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check(rd, 32'hBD);
    check(e, 1'b0);
    apb(1'b0, LEVEL_ADDR, 32'h0);
    check(rd, 32'h0A);
  endtask

  initial begin
    rst_b    = 1'b0;
    pin_a_in = 1'b1;
    pin_b_in = 1'b1;
    apb_req  = '0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_ctrl();
    t_level();
    t_unmapped();
    // second reset in mid-run with settings loaded
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    complete_run();
  end
endmodule // test_dac_control_registers
